// ==== cpu_regs_pkg.sv ====
// Shared constants and types for the processor pointer and flag registers.
// Assumes a single 200 MHz clock and an APB master for software access.
package cpu_regs_pkg;

    localparam logic [7:0] off_accum = 8'h00;
    localparam logic [7:0] off_index = 8'h04;
    localparam logic [7:0] off_stack = 8'h08;
    localparam logic [7:0] off_pc = 8'h0C;
    localparam logic [7:0] off_flags = 8'h10;
    localparam logic [7:0] off_status = 8'h14;

    localparam int flag_v_pos = 7;
    localparam int flag_one6_pos = 6;
    localparam int flag_one5_pos = 5;
    localparam int flag_h_pos = 4;
    localparam int flag_i_pos = 3;
    localparam int flag_n_pos = 2;
    localparam int flag_z_pos = 1;
    localparam int flag_c_pos = 0;

    localparam logic [7:0] idx_hi_reset = 8'h00;
    localparam logic [15:0] stack_reset = 16'h00FF;
    localparam logic [7:0] stack_low_reset = 8'hFF;
    localparam logic [7:0] flags_reset = 8'h68;
    localparam logic [7:0] flags_fixed_ones = 8'h60;

    typedef enum logic [4:0] {
        op_nop = 5'h00,
        op_load_x = 5'h01,
        op_load_hx = 5'h02,
        op_clr_x = 5'h03,
        op_inc_x = 5'h04,
        op_dec_x = 5'h05,
        op_com_x = 5'h06,
        op_neg_x = 5'h07,
        op_lsl_x = 5'h08,
        op_lsr_x = 5'h09,
        op_asr_x = 5'h0A,
        op_rol_x = 5'h0B,
        op_ror_x = 5'h0C,
        op_tax = 5'h0D,
        op_txa = 5'h0E,
        op_add = 5'h0F,
        op_adc = 5'h10,
        op_sub = 5'h11,
        op_decimal_adjust = 5'h12,
        op_add_imm_to_stack = 5'h13,
        op_stack_low_reset = 5'h14,
        op_load_sp = 5'h15,
        op_push = 5'h16,
        op_pull = 5'h17,
        op_change_flow = 5'h18,
        op_branch = 5'h19,
        op_clear_mask = 5'h1A,
        op_set_mask = 5'h1B,
        op_tap = 5'h1C,
        op_int_entry = 5'h1D,
        op_load_a = 5'h1E,
        op_set_carry = 5'h1F
    } op_code_t;

    typedef struct packed {
        logic v;
        logic one6;
        logic one5;
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } flags_t;

    typedef struct packed {
        logic valid;
        op_code_t code;
        logic [15:0] data;
        logic [7:0] imm;
    } op_req_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] idx_hi;
        logic [7:0] idx_lo;
        logic [15:0] sp;
        logic [15:0] pc;
        flags_t flags;
        logic inhibit;
        logic [31:0] rdata;
        logic slverr;
    } regs_state_t;

endpackage

// ==== cpu_pointer_and_flag_regs.sv ====
// Processor accumulator, index pair, stack pointer, program counter and
// condition flags, with an operation port from the instruction datapath.
// Assumes the datapath presents at most one operation per clock and that
// memory supplies the reset vector on the reset_vector input.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Functional notes
// - Index high and low bytes combine into one 16-bit pointer, high first.
// - Indexed accesses use the full pair; legacy ops touch only the low byte.
// - Low index byte supports clear, inc, dec, com, neg, shifts, A transfers.
// - Reset forces the high index byte to zero; low byte keeps its value.
// - Stack pointer always addresses the next free stack location.
// - Add-immediate-to-stack sign-extends an 8-bit value and adds it.
// - Reset loads the stack pointer with 0x00FF.
// - Stack low reset op changes only the low byte of the stack pointer.
// - Program counter advances by one for every fetched byte.
// - Jumps, branches, interrupts and returns load a non-sequential address.
// - Leaving reset, program counter takes the vector from the top two bytes.
// - Flag bits 6 and 5 always read one and ignore writes.
// - Overflow flag bit 7 follows two's complement overflow.
// - Half-carry bit 4 records carry from bit 3 into bit 4 on adds.
// - Decimal adjust corrects a BCD add result using half-carry and carry.
// - Mask bit 3 blocks maskable interrupts when one.
// - Interrupt entry sets the mask after stacking, before the handler runs.
// - After an op clears the mask, the next boundary accepts no interrupt.
// - Negative flag copies the top bit of results and loaded values.
// - Zero flag is set when a result or loaded value is all zero.
// - Carry flag bit 0 follows add carry, subtract borrow, shifts and tests.
// - Accumulator keeps its contents across reset.
module cpu_pointer_and_flag_regs
    import cpu_regs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,

    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    input wire op_req_t op_req,
    input wire logic fetch_strobe,
    input wire logic [15:0] reset_vector,

    input wire logic insn_boundary,
    input wire logic irq_request,
    output logic irq_accept,

    output logic [15:0] index_ptr,
    output logic [15:0] stack_ptr,
    output logic [15:0] program_counter,
    output logic [7:0] condition_flags,
    output logic [7:0] accumulator
);

    regs_state_t state_ff;
    regs_state_t nxt_state;

    ////////////////////////////////////////////////////////////////////////////////

    // Sets N and Z from an 8-bit value.
    function automatic flags_t nz8(input flags_t f, input logic [7:0] val);
        flags_t r;

        r = f;
        r.n = val[7];
        r.z = (val == 8'h00);
        return r;
    endfunction

    // Adds or subtracts with carry in; result in [8:1], updated flags in [16:9].
    function automatic logic [16:0] alu_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub,
                                           input flags_t f);
        logic [8:0] sum;
        logic [4:0] low;
        logic [7:0] bb;
        flags_t r;

        bb = sub ? ~b : b;
        sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin ^ sub};
        low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin ^ sub};
        r = nz8(f, sum[7:0]);
        r.v = (a[7] == bb[7]) && (sum[7] != a[7]);
        if (!sub) begin
            r.h = low[4];
        end
        r.c = sub ? ~sum[8] : sum[8];

        return {r, sum[7:0], 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic [16:0] alu;
        logic [7:0] corr;
        logic [7:0] tmp;
        flags_t f;

        alu = '0;
        corr = 8'h00;
        tmp = 8'h00;
        nxt_state = state_ff;
        f = state_ff.flags;

        if (fetch_strobe) begin
            nxt_state.pc = state_ff.pc + 16'h0001;
        end

        // The inhibit lasts only across the first boundary after the clear.
        // Dropped ahead of the operations, so a clear in this cycle re-arms it.
        if (insn_boundary && state_ff.inhibit) begin
            nxt_state.inhibit = 1'b0;
        end

        if (op_req.valid) begin
            case (op_req.code)
                op_load_x: begin
                    nxt_state.idx_lo = op_req.data[7:0];
                    f = nz8(f, op_req.data[7:0]);
                    f.v = 1'b0;
                end

                op_load_hx: begin
                    nxt_state.idx_hi = op_req.data[15:8];
                    nxt_state.idx_lo = op_req.data[7:0];
                    f.n = op_req.data[15];
                    f.z = (op_req.data == 16'h0000);
                    f.v = 1'b0;
                end

                op_load_a: begin
                    nxt_state.acc = op_req.data[7:0];
                    f = nz8(f, op_req.data[7:0]);
                    f.v = 1'b0;
                end

                op_clr_x: begin
                    nxt_state.idx_lo = 8'h00;
                    f = nz8(f, 8'h00);
                    f.v = 1'b0;
                end

                op_inc_x: begin
                    tmp = state_ff.idx_lo + 8'h01;
                    nxt_state.idx_lo = tmp;
                    f = nz8(f, tmp);
                    f.v = (tmp == 8'h80);
                end

                op_dec_x: begin
                    tmp = state_ff.idx_lo - 8'h01;
                    nxt_state.idx_lo = tmp;
                    f = nz8(f, tmp);
                    f.v = (tmp == 8'h7F);
                end

                op_com_x: begin
                    tmp = ~state_ff.idx_lo;
                    nxt_state.idx_lo = tmp;
                    f = nz8(f, tmp);
                    f.v = 1'b0;
                    f.c = 1'b1;
                end

                op_neg_x: begin
                    tmp = 8'h00 - state_ff.idx_lo;
                    nxt_state.idx_lo = tmp;
                    f = nz8(f, tmp);
                    f.v = (tmp == 8'h80);
                    f.c = (tmp != 8'h00);
                end

                op_lsl_x, op_lsr_x, op_asr_x, op_rol_x, op_ror_x: begin
                    case (op_req.code)
                        op_lsl_x: tmp = {state_ff.idx_lo[6:0], 1'b0};
                        op_lsr_x: tmp = {1'b0, state_ff.idx_lo[7:1]};
                        op_asr_x: tmp = {state_ff.idx_lo[7], state_ff.idx_lo[7:1]};
                        op_rol_x: tmp = {state_ff.idx_lo[6:0], state_ff.flags.c};
                        op_ror_x: tmp = {state_ff.flags.c, state_ff.idx_lo[7:1]};
                        default: tmp = state_ff.idx_lo;
                    endcase

                    nxt_state.idx_lo = tmp;
                    f = nz8(f, tmp);
                    // Left shifts push bit 7 into carry, right shifts bit 0.
                    if (op_req.code == op_lsl_x || op_req.code == op_rol_x) begin
                        f.c = state_ff.idx_lo[7];
                    end else begin
                        f.c = state_ff.idx_lo[0];
                    end
                    f.v = f.n ^ f.c;
                end

                op_tax: begin
                    nxt_state.idx_lo = state_ff.acc;
                end

                op_txa: begin
                    nxt_state.acc = state_ff.idx_lo;
                end

                op_add, op_adc, op_sub: begin
                    alu = alu_add(state_ff.acc, op_req.data[7:0],
                                  (op_req.code == op_adc) & state_ff.flags.c,
                                  op_req.code == op_sub, f);
                    nxt_state.acc = alu[8:1];
                    f = flags_t'(alu[16:9]);
                end

                op_decimal_adjust: begin
                    // Low digit is corrected on half-carry or a digit above nine.
                    if (state_ff.flags.h || (state_ff.acc[3:0] > 4'h9)) begin
                        corr[3:0] = 4'h6;
                    end
                    // High digit is corrected on carry or a value above 0x99.
                    if (state_ff.flags.c || (state_ff.acc > 8'h99)) begin
                        corr[7:4] = 4'h6;
                    end

                    tmp = state_ff.acc + corr;
                    nxt_state.acc = tmp;
                    f = nz8(f, tmp);
                    f.c = state_ff.flags.c | (corr[7:4] != 4'h0);
                end

                op_add_imm_to_stack: begin
                    nxt_state.sp = state_ff.sp + {{8{op_req.imm[7]}}, op_req.imm};
                end

                op_stack_low_reset: begin
                    nxt_state.sp = {state_ff.sp[15:8], stack_low_reset};
                end

                op_load_sp: begin
                    nxt_state.sp = op_req.data;
                end

                op_push: begin
                    // The pointer is left on the next free byte below the one written.
                    nxt_state.sp = state_ff.sp - 16'h0001;
                end

                op_pull: begin
                    nxt_state.sp = state_ff.sp + 16'h0001;
                end

                op_change_flow: begin
                    nxt_state.pc = op_req.data;
                end

                op_branch: begin
                    // Offset is from the PC before this cycle's fetch step.
                    nxt_state.pc = state_ff.pc + {{8{op_req.imm[7]}}, op_req.imm};
                end

                op_clear_mask: begin
                    f.i = 1'b0;
                    nxt_state.inhibit = state_ff.flags.i;
                end

                op_set_mask: begin
                    f.i = 1'b1;
                end

                op_tap: begin
                    // Copying A may clear I, which arms the hold-off.
                    f = flags_t'(state_ff.acc | flags_fixed_ones);
                    nxt_state.inhibit = state_ff.flags.i & ~state_ff.acc[flag_i_pos];
                end

                op_int_entry: begin
                    // Issued once stacking is done, before the handler's first fetch.
                    f.i = 1'b1;
                    nxt_state.pc = op_req.data;
                end

                op_set_carry: begin
                    f.c = op_req.imm[0];
                end

                default: begin
                end
            endcase
        end

        // Software writes land in the access phase and override the datapath.
        if (psel && penable && pwrite) begin
            case (paddr)
                off_accum: nxt_state.acc = pwdata[7:0];

                off_index: begin
                    nxt_state.idx_hi = pwdata[15:8];
                    nxt_state.idx_lo = pwdata[7:0];
                end

                off_stack: nxt_state.sp = pwdata[15:0];

                off_pc: nxt_state.pc = pwdata[15:0];

                off_flags: f = flags_t'(pwdata[7:0]);

                default: begin
                end
            endcase
        end

        f.one6 = 1'b1;
        f.one5 = 1'b1;
        nxt_state.flags = f;

        // Read data is captured in the setup phase so it comes from a flop.
        nxt_state.rdata = 32'h0000_0000;
        nxt_state.slverr = 1'b0;

        if (psel && !penable) begin
            case (paddr)
                off_accum: nxt_state.rdata = {24'h000000, state_ff.acc};
                off_index: nxt_state.rdata = {16'h0000, state_ff.idx_hi, state_ff.idx_lo};
                off_stack: nxt_state.rdata = {16'h0000, state_ff.sp};
                off_pc: nxt_state.rdata = {16'h0000, state_ff.pc};
                off_flags: nxt_state.rdata = {24'h000000, state_ff.flags};
                off_status: nxt_state.rdata = {31'h0000_0000, state_ff.inhibit};
                default: nxt_state.slverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // The accumulator and low index byte are left out of reset on purpose.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff.idx_hi <= idx_hi_reset;
            state_ff.sp <= stack_reset;
            // Memory presents the vector while reset is held.
            state_ff.pc <= reset_vector;
            state_ff.flags <= flags_t'(flags_reset);
            state_ff.inhibit <= 1'b0;
            state_ff.rdata <= 32'h0000_0000;
            state_ff.slverr <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // No wait states: every access ends in its first access cycle.
    assign pready = 1'b1;
    assign prdata = state_ff.rdata;
    // The error only shows while the access phase stands.
    assign pslverr = state_ff.slverr & psel & penable;

    assign index_ptr = {state_ff.idx_hi, state_ff.idx_lo};
    assign stack_ptr = state_ff.sp;
    assign program_counter = state_ff.pc;
    assign condition_flags = state_ff.flags;
    assign accumulator = state_ff.acc;

    assign irq_accept = irq_request & insn_boundary & ~state_ff.flags.i
                      & ~state_ff.inhibit;

endmodule

// ==== cpu_regs_checker.sv ====
// Port-level checker for the pointer and flag registers, bound to the top module.
// Assumes one clock, a synchronous active-low reset and the shared package.
`timescale 1ns/1ps
module cpu_regs_checker
    import cpu_regs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire op_req_t op_req,
    input wire logic fetch_strobe,
    input wire logic [15:0] reset_vector,
    input wire logic insn_boundary,
    input wire logic irq_request,
    input wire logic irq_accept,
    input wire logic [15:0] index_ptr,
    input wire logic [15:0] stack_ptr,
    input wire logic [15:0] program_counter,
    input wire logic [7:0] condition_flags,
    input wire logic [7:0] accumulator
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // A bus write wins over an operation, so edges carrying one are left out.
    logic apb_wr;
    assign apb_wr = psel && penable && pwrite;
    sequence s_op(op_code_t k);
        op_req.valid && op_req.code == k && !apb_wr;
    endsequence
    sequence s_unmask;
        s_op(op_clear_mask) ##0 condition_flags[3];
    endsequence
    ////////////////////////////////////////
    property p_reset_vals;
        $rose(reset_n) |-> stack_ptr == 16'h00FF && index_ptr[15:8] == 8'h00
            && program_counter == $past(reset_vector);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
    property p_fixed_ones;
        condition_flags[6:5] == 2'b11;
    endproperty
    a_fixed_ones: assert property (p_fixed_ones) else $error("fixed flag bits low");
    property p_fetch;
        fetch_strobe && !op_req.valid && !apb_wr |=> program_counter == $past(program_counter) + 16'h0001;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch did not advance");
    property p_ais;
        s_op(op_add_imm_to_stack) |=> stack_ptr == $past(stack_ptr) + {{8{$past(op_req.imm[7])}}, $past(op_req.imm)};
    endproperty
    a_ais: assert property (p_ais) else $error("stack add wrong");
    property p_low_reset;
        s_op(op_stack_low_reset) |=> stack_ptr == {$past(stack_ptr[15:8]), 8'hFF};
    endproperty
    a_low_reset: assert property (p_low_reset) else $error("stack low reset wrong");
    property p_int;
        s_op(op_int_entry) |=> condition_flags[3] && program_counter == $past(op_req.data);
    endproperty
    a_int: assert property (p_int) else $error("interrupt entry wrong");
    property p_mask;
        irq_accept |-> irq_request && insn_boundary && !condition_flags[3];
    endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt accepted");
    property p_inhibit;
        s_unmask ##1 insn_boundary |-> !irq_accept;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("accepted after unmask");
    property p_load_nz;
        s_op(op_load_x) |=> condition_flags[2] == $past(op_req.data[7])
            && condition_flags[1] == ($past(op_req.data[7:0]) == 8'h00);
    endproperty
    a_load_nz: assert property (p_load_nz) else $error("load flags wrong");
endmodule
bind cpu_pointer_and_flag_regs cpu_regs_checker u_chk (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_req(op_req),
    .fetch_strobe(fetch_strobe), .reset_vector(reset_vector), .insn_boundary(insn_boundary),
    .irq_request(irq_request), .irq_accept(irq_accept), .index_ptr(index_ptr),
    .stack_ptr(stack_ptr), .program_counter(program_counter),
    .condition_flags(condition_flags), .accumulator(accumulator));

// ==== tb.sv ====
// Self-checking bench for the pointer and flag registers.
// Assumes the package, the design and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb;
    import cpu_regs_pkg::*;
    typedef struct {int k; logic [31:0] e; logic [31:0] m;} note_t;
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, a, b, r, m;
    logic [31:0] pwdata = 32'h0, prdata, rd_data;
    logic pready, pslverr, rd_err, irq_accept, c, ci, cn, h, v;
    op_req_t op_req = '0;
    op_code_t k;
    logic fetch_strobe = 1'b0, insn_boundary = 1'b0, irq_request = 1'b0;
    logic [15:0] reset_vector = 16'h0000, index_ptr, stack_ptr, program_counter;
    logic [7:0] condition_flags, accumulator;
    logic [23:0] daa_tab [3] = '{24'h453883, 24'h990100, 24'h584705};
    int failures = 0, cmp_count = 0, cycles = 0;
    note_t q[$];
    always #2.5 clk = ~clk;
    cpu_pointer_and_flag_regs u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_req(op_req), .fetch_strobe(fetch_strobe),
        .reset_vector(reset_vector), .insn_boundary(insn_boundary), .irq_request(irq_request),
        .irq_accept(irq_accept), .index_ptr(index_ptr), .stack_ptr(stack_ptr),
        .program_counter(program_counter), .condition_flags(condition_flags),
        .accumulator(accumulator));
    ////////////////////////////////////////
    function automatic logic [31:0] seen(int n);
        case (n)
            0: return {16'h0, index_ptr};
            1: return {16'h0, stack_ptr};
            2: return {16'h0, program_counter};
            3: return {24'h0, condition_flags};
            4: return {24'h0, accumulator};
            5: return rd_data;
            6: return {31'h0, rd_err};
            default: return {31'h0, irq_accept};
        endcase
    endfunction
    // Notes are compared just after the edge, once that edge's updates have landed.
    always @(posedge clk) begin
        note_t n;
        #1;
        while (q.size() > 0) begin
            n = q.pop_front();
            `CHK(seen(n.k) & n.m, n.e & n.m)
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic note(int n, logic [31:0] e, logic [31:0] mk = 32'hFFFFFFFF);
        q.push_back('{n, e, mk});
    endtask
    task automatic done(string s);
        @(posedge clk);
        $display("test %s finished", s);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Each operation is followed by one idle edge, so valid never toggles twice at once.
    task automatic op(op_code_t o, logic [15:0] d = 16'h0, logic [7:0] im = 8'h00);
        op_req <= '{1'b1, o, d, im};
        @(posedge clk);
        op_req <= '0;
        @(posedge clk);
    endtask
    function automatic logic [8:0] xop(op_code_t o, logic [7:0] x, logic i);
        case (o)
            op_clr_x: return {i, 8'h00};
            op_inc_x: return {i, x + 8'h01};
            op_dec_x: return {i, x - 8'h01};
            op_com_x: return {i, ~x};
            op_neg_x: return {i, 8'h00 - x};
            op_lsl_x: return {x, 1'b0};
            op_lsr_x: return {x[0], 1'b0, x[7:1]};
            op_asr_x: return {x[0], x[7], x[7:1]};
            op_rol_x: return {x, i};
            default: return {x[0], i, x[7:1]};
        endcase
    endfunction
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'hACA90F01));
        reset_vector <= 16'($urandom());
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        note(1, 32'h00FF);
        note(0, 32'h0000, 32'hFF00);
        note(2, {16'h0, reset_vector});
        apb(1'b1, off_flags, 32'h0);
        apb(1'b0, off_flags, 32'h0);
        note(5, 32'h60);
        apb(1'b0, 8'h18, 32'h0);
        note(6, 32'h1);
        done("reset_and_bus");
        op(op_load_hx, 16'hC300);
        for (int i = 0; i < 30; i++) begin
            b = 8'($urandom());
            c = 1'($urandom());
            k = op_code_t'(5'h03 + 5'($urandom_range(9)));
            op(op_load_x, {8'h00, b});
            op(op_set_carry, 16'h0, {7'h0, c});
            op(k);
            {cn, r} = xop(k, b, c);
            note(0, {16'hC3, r});
            note(3, {24'h0, 5'h0, r[7], r == 8'h00, cn}, (k >= op_lsl_x) ? 32'h7 : 32'h6);
        end
        op(op_load_a, 16'h005C);
        op(op_tax);
        note(0, 32'hC35C, 32'hFFFF);
        op(op_inc_x);
        op(op_txa);
        note(4, 32'h5D);
        done("index");
        for (int i = 0; i < 30; i++) begin
            a = 8'($urandom());
            b = 8'($urandom());
            c = 1'($urandom());
            k = op_code_t'(5'h0F + 5'($urandom_range(2)));
            op(op_set_carry, 16'h0, {7'h0, c});
            op(op_load_a, {8'h00, a});
            op(k, {8'h00, b});
            ci = (k == op_adc) ? c : 1'b0;
            if (k == op_sub) begin
                r = a - b;
                cn = b > a;
                h = 1'b0;
                v = (a[7] != b[7]) && (r[7] != a[7]);
                m = 8'h87;
            end else begin
                {cn, r} = {1'b0, a} + {1'b0, b} + {8'h0, ci};
                h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0F;
                v = (a[7] == b[7]) && (r[7] != a[7]);
                m = 8'h97;
            end
            note(4, {24'h0, r});
            note(3, {24'h0, v, 2'b11, h, 1'b0, r[7], r == 8'h00, cn}, {24'h0, m});
        end
        for (int i = 0; i < 3; i++) begin
            op(op_load_a, {8'h00, daa_tab[i][23:16]});
            op(op_add, {8'h00, daa_tab[i][15:8]});
            op(op_decimal_adjust);
            note(4, {24'h0, daa_tab[i][7:0]});
            note(3, {31'h0, i != 0}, 32'h1);
        end
        done("arith");
        op(op_load_sp, 16'h1234);
        op(op_add_imm_to_stack, 16'h0, 8'h80);
        note(1, 32'h11B4);
        op(op_add_imm_to_stack, 16'h0, 8'h7F);
        op(op_push);
        note(1, 32'h1232);
        op(op_pull);
        note(1, 32'h1233);
        op(op_stack_low_reset);
        note(1, 32'h12FF);
        op(op_load_hx, 16'hFFFE);
        op(op_load_x, 16'h0000);
        note(3, 32'h02, 32'h06);
        op(op_change_flow, 16'hFFFE);
        fetch_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        fetch_strobe <= 1'b0;
        @(posedge clk);
        note(2, 32'h0001);
        op(op_branch, 16'h0, 8'hF0);
        note(2, 32'hFFF1);
        done("pointers");
        op(op_set_mask);
        irq_request <= 1'b1;
        insn_boundary <= 1'b1;
        note(7, 32'h0);
        @(posedge clk);
        insn_boundary <= 1'b0;
        op_req <= '{1'b1, op_clear_mask, 16'h0, 8'h00};
        @(posedge clk);
        op_req <= '0;
        insn_boundary <= 1'b1;
        note(7, 32'h0);
        @(posedge clk);
        note(7, 32'h1);
        @(posedge clk);
        insn_boundary <= 1'b0;
        irq_request <= 1'b0;
        op(op_int_entry, 16'h8000);
        note(2, 32'h8000);
        note(3, 32'h08, 32'h08);
        op(op_load_a);
        op(op_tap);
        note(3, 32'h60);
        apb(1'b0, off_status, 32'h0);
        note(5, 32'h1);
        done("interrupt");
        op(op_load_a, 16'h005A);
        op(op_load_hx, 16'h3CA5);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        note(4, 32'h5A);
        note(0, 32'h00A5);
        note(1, 32'h00FF);
        done("mid_reset");
        conclude();
    end
endmodule
